// file: logic/ppsrd_pkg.sv
/*
 * Shared constants and types of the power-state and receiver-detect controller:
 * power-state codes, status codes, compliance symbols, register map and timing counts.
 * Assumes a 200 MHz system clock shared by all modules of the block.
 */
package ppsrd_pkg;
	// ------------------------------------------------------------
	// power states and status codes on the transceiver pins
	// ------------------------------------------------------------
	localparam logic [1:0] PS_P0 = 2'b00;
	localparam logic [1:0] PS_P0S = 2'b01;
	localparam logic [1:0] PS_P1 = 2'b10;
	localparam logic [1:0] PS_P2 = 2'b11;
	localparam logic [2:0] STAT_RX_FOUND = 3'b011;
	localparam logic [2:0] STAT_NONE = 3'b000;

	// ------------------------------------------------------------
	// compliance pattern symbols
	// ------------------------------------------------------------
	localparam logic [7:0] SYM_K28_5 = 8'hbc;
	localparam logic [7:0] SYM_D21_5 = 8'hb5;
	localparam logic [7:0] SYM_D10_2 = 8'h4a;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int IDLE_MIN_NS = 20;
	localparam int IDLE_MIN_CYC_I = (IDLE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [3:0] IDLE_MIN_CYC = 4'(IDLE_MIN_CYC_I);
	localparam logic [3:0] DET_LEAD_CYC = 4'ha;
	localparam logic [3:0] IDLE_CNT_MAX = 4'hf;

	// ------------------------------------------------------------
	// register map and fields
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CMD = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam int CTRL_PS_LSB = 0;
	localparam int CTRL_LOOP_BIT = 2;
	localparam int CTRL_BEACON_BIT = 3;
	localparam int CTRL_COMPL_BIT = 4;
	localparam int CTRL_WIDE_BIT = 5;
	localparam int CMD_PWR_BIT = 0;
	localparam int CMD_DET_BIT = 1;
	localparam int ST_PS_LSB = 0;
	localparam int ST_BUSY_BIT = 2;
	localparam int ST_DETDONE_BIT = 3;
	localparam int ST_FOUND_BIT = 4;
	localparam int ST_PWRDONE_BIT = 5;
	localparam int ST_RAW_LSB = 8;
	localparam logic [1:0] RST_PS = PS_P1;

	typedef enum logic [1:0] {FSM_IDLE, FSM_PWR_WAIT, FSM_DET_LEAD, FSM_DET_WAIT} ppsrd_fsm_t;
endpackage

// file: logic/ppsrd_if.sv
/*
 * Carriers between the controller core and its helpers: register access
 * from the bus slave, and the compliance transmit lane.
 * Assumes all parties run on the same clock.
 */
`timescale 1ns/1ps
interface ppsrd_reg_if;
	logic wr;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	modport slave (output wr, output addr, output wdata, input rdata);
	modport core (input wr, input addr, input wdata, output rdata);
endinterface

interface ppsrd_tx_if;
	logic en;
	logic wide;
	logic [15:0] data;
	logic [1:0] ctrl;
	logic [1:0] disp;
	modport gen (input en, input wide, output data, output ctrl, output disp);
	modport core (output en, output wide, input data, input ctrl, input disp);
endinterface

// file: logic/ppsrd_ahb_slave.sv
/*
 * AHB-Lite slave front end: zero-wait single word transfers, always OKAY.
 * Assumes it is the only slave, so hready equals its own hreadyout.
 */
`timescale 1ns/1ps
module ppsrd_ahb_slave (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// ahb-lite
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// register access
	ppsrd_reg_if.slave regs
);
	typedef struct packed {
		logic wrPh;
		logic rdPh;
		logic [7:0] addr;
	} ppsrd_ahb_state_t;

	ppsrd_ahb_state_t st_reg, st_next;
	logic accept;

	// only word transfers inside the block's window are taken; others read as zero
	assign accept = hsel && hready && htrans[1] && (hsize == 3'h2) && (haddr[31:ppsrd_pkg::ADDR_W] == '0);

	always_comb
	begin
		st_next = st_reg;
		st_next.wrPh = accept && hwrite;
		st_next.rdPh = accept && !hwrite;
		if (accept)
			st_next.addr = haddr[7:0];
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign regs.wr = st_reg.wrPh;
	assign regs.addr = st_reg.addr;
	assign regs.wdata = hwdata;
	assign hrdata = st_reg.rdPh ? regs.rdata : 32'h00000000;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
endmodule

// file: logic/ppsrd_compliance_gen.sv
/*
 * Compliance pattern source for the transmit lane, 8-bit or 16-bit wide,
 * with the forced-negative-disparity strobe on the first comma.
 * Assumes the core holds en only while the lane is in the normal power state.
 */
`timescale 1ns/1ps
module ppsrd_compliance_gen (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// lane
	ppsrd_tx_if.gen tx
);
	typedef struct packed {
		logic [1:0] idx;
		logic [15:0] data;
		logic [1:0] ctrl;
		logic [1:0] disp;
	} ppsrd_gen_state_t;

	ppsrd_gen_state_t st_reg, st_next;

	always_comb
	begin
		st_next = st_reg;
		st_next.idx = 2'h0;
		st_next.data = 16'h0000;
		st_next.ctrl = 2'h0;
		st_next.disp = 2'h0;
		if (tx.en && tx.wide)
		begin
			// low byte goes first on the wire
			st_next.idx = {1'b0, ~st_reg.idx[0]};
			st_next.ctrl = 2'h1;
			st_next.data = st_reg.idx[0] ? {ppsrd_pkg::SYM_D10_2, ppsrd_pkg::SYM_K28_5}
				: {ppsrd_pkg::SYM_D21_5, ppsrd_pkg::SYM_K28_5};
			st_next.disp = st_reg.idx[0] ? 2'h0 : 2'h1;
		end
		else if (tx.en)
		begin
			st_next.idx = st_reg.idx + 2'h1;
			unique case (st_reg.idx)
				2'h0: st_next.data = {8'h00, ppsrd_pkg::SYM_K28_5};
				2'h1: st_next.data = {8'h00, ppsrd_pkg::SYM_D21_5};
				2'h2: st_next.data = {8'h00, ppsrd_pkg::SYM_K28_5};
				2'h3: st_next.data = {8'h00, ppsrd_pkg::SYM_D10_2};
			endcase
			st_next.ctrl = {1'b0, ~st_reg.idx[0]};
			st_next.disp = {1'b0, st_reg.idx == 2'h0};
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign tx.data = st_reg.data;
	assign tx.ctrl = st_reg.ctrl;
	assign tx.disp = st_reg.disp;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence narrowPattern;
		(tx.data[7:0] == ppsrd_pkg::SYM_K28_5) && tx.ctrl[0] ##1 (tx.data[7:0] == ppsrd_pkg::SYM_D21_5) && !tx.disp[0]
			##1 (tx.data[7:0] == ppsrd_pkg::SYM_K28_5) && !tx.disp[0];
	endsequence
	sequence widePattern;
		(tx.data == {ppsrd_pkg::SYM_D21_5, ppsrd_pkg::SYM_K28_5}) && (tx.ctrl == 2'h1)
			##1 (tx.data == {ppsrd_pkg::SYM_D10_2, ppsrd_pkg::SYM_K28_5}) && (tx.disp == 2'h0);
	endsequence

	narrow_disp_a: assert property (@(posedge clock) disable iff (sys_rst)
		tx.disp[0] && !tx.wide && $past(tx.en) && tx.en |-> narrowPattern)
		else $error("narrow disparity strobe not on first comma");
	wide_disp_a: assert property (@(posedge clock) disable iff (sys_rst)
		tx.disp != 2'h0 && tx.wide && $past(tx.en) && tx.en |-> tx.disp == 2'h1 ##0 widePattern)
		else $error("wide disparity strobe wrong");
	pattern_repeat_a: assert property (@(posedge clock) disable iff (sys_rst)
		tx.disp[0] && !tx.wide && tx.en ##1 (tx.en && !tx.wide)[*3] |=> tx.disp[0])
		else $error("compliance pattern does not repeat every four symbols");
endmodule

// file: logic/ppsrd_ctrl.sv
/*
 * Top of the link-layer side controller for one transceiver channel: drives the
 * power-state, force-idle, detect/loopback and compliance lines, and reports over AHB-Lite.
 * Assumes the transceiver runs on this same 200 MHz clock domain at its pins, but its
 * status inputs are still resynchronised, and that the system supplies the 125 MHz aux clock.
 */
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
// What this block does
// - two-bit code selects P0, P0s, P1, P2
// - no new request before previous completion
// - P0 keeps force-idle low; loopback optional
// - P0s and P1 hold force-idle high
// - P2 releases force-idle only for beacon
// - electrical idle lasts at least 20 ns
// - system supplies 125 MHz aux clock
// - detect request drives both lines high
// - force-idle leads detect by ten cycles
// - compliance sends K28.5 D21.5 K28.5 D10.2
// - 8-bit: strobe on first K28.5 cycle
// - 16-bit: only bit 0, K28.5/D21.5 cycle
`timescale 1ns/1ps
module ppsrd_ctrl (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// ahb-lite
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// transceiver control
	output logic [1:0] txPowerDown,
	output logic txForceIdle,
	output logic txDetectRxLoop,
	output logic [15:0] txData,
	output logic [1:0] txCtrl,
	output logic [1:0] txForceDisp,
	// transceiver status
	input wire logic phyDoneStatus,
	input wire logic [2:0] phyStatus
);
	typedef struct packed {
		ppsrd_pkg::ppsrd_fsm_t fsm;
		logic [1:0] pd;
		logic [1:0] curPs;
		logic forceIdle;
		logic detRx;
		logic [3:0] idleCnt;
		logic [1:0] tgtPs;
		logic loopEn;
		logic beaconEn;
		logic complEn;
		logic wide;
		logic pwrReq;
		logic detDone;
		logic found;
		logic pwrDone;
		logic [2:0] rawStat;
		logic doneS1;
		logic doneS2;
		logic [2:0] statS1;
		logic [2:0] statS2;
	} ppsrd_ctrl_state_t;

	ppsrd_ctrl_state_t st_reg, st_next;
	ppsrd_reg_if regs();
	ppsrd_tx_if tx();
	logic cmdWr;
	logic cmdPwr;
	logic cmdDet;
	logic holdOk;
	logic busy;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	ppsrd_ahb_slave u_slave (
		.clock(clock),
		.sys_rst(sys_rst),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.regs(regs.slave)
	);

	ppsrd_compliance_gen u_gen (
		.clock(clock),
		.sys_rst(sys_rst),
		.tx(tx.gen)
	);

	// force-idle wanted for a given power state and beacon setting
	function automatic logic wantIdle(input logic [1:0] ps, input logic beacon);
		logic w;
		w = 1'b1;
		unique case (ps)
			ppsrd_pkg::PS_P0: w = 1'b0;
			ppsrd_pkg::PS_P0S: w = 1'b1;
			ppsrd_pkg::PS_P1: w = 1'b1;
			ppsrd_pkg::PS_P2: w = !beacon;
		endcase
		return w;
	endfunction

	assign cmdWr = regs.wr && (regs.addr == ppsrd_pkg::OFF_CMD);
	assign cmdPwr = cmdWr && regs.wdata[ppsrd_pkg::CMD_PWR_BIT];
	assign cmdDet = cmdWr && regs.wdata[ppsrd_pkg::CMD_DET_BIT];
	// release of idle is allowed only once it has lasted the minimum time
	assign holdOk = !st_reg.forceIdle || (st_reg.idleCnt >= ppsrd_pkg::IDLE_MIN_CYC - 4'h1);
	assign busy = (st_reg.fsm != ppsrd_pkg::FSM_IDLE) || st_reg.pwrReq;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		st_next = st_reg;
		st_next.doneS1 = phyDoneStatus;
		st_next.doneS2 = st_reg.doneS1;
		st_next.statS1 = phyStatus;
		st_next.statS2 = st_reg.statS1;
		if (regs.wr && regs.addr == ppsrd_pkg::OFF_CTRL)
		begin
			st_next.tgtPs = regs.wdata[ppsrd_pkg::CTRL_PS_LSB +: 2];
			st_next.loopEn = regs.wdata[ppsrd_pkg::CTRL_LOOP_BIT];
			st_next.beaconEn = regs.wdata[ppsrd_pkg::CTRL_BEACON_BIT];
			st_next.complEn = regs.wdata[ppsrd_pkg::CTRL_COMPL_BIT];
			st_next.wide = regs.wdata[ppsrd_pkg::CTRL_WIDE_BIT];
		end
		// write-one-to-clear; a set in the same cycle below wins
		if (regs.wr && regs.addr == ppsrd_pkg::OFF_STATUS)
		begin
			if (regs.wdata[ppsrd_pkg::ST_DETDONE_BIT])
				st_next.detDone = 1'b0;
			if (regs.wdata[ppsrd_pkg::ST_PWRDONE_BIT])
				st_next.pwrDone = 1'b0;
		end
		if (cmdPwr)
			st_next.pwrReq = 1'b1;
		unique case (st_reg.fsm)
			ppsrd_pkg::FSM_IDLE:
			begin
				if (st_reg.pwrReq && st_reg.tgtPs == st_reg.curPs)
					st_next.pwrReq = 1'b0;
				else if (st_reg.pwrReq && (wantIdle(st_reg.tgtPs, st_reg.beaconEn) || holdOk))
				begin
					// the new code is the request; one outstanding at a time
					st_next.pd = st_reg.tgtPs;
					st_next.pwrReq = cmdPwr;
					st_next.fsm = ppsrd_pkg::FSM_PWR_WAIT;
				end
				else if (!st_reg.pwrReq && cmdDet && st_reg.curPs == ppsrd_pkg::PS_P1)
					st_next.fsm = ppsrd_pkg::FSM_DET_LEAD;
			end
			ppsrd_pkg::FSM_PWR_WAIT:
			begin
				if (st_reg.doneS2)
				begin
					st_next.curPs = st_reg.pd;
					st_next.pwrDone = 1'b1;
					st_next.fsm = ppsrd_pkg::FSM_IDLE;
				end
			end
			ppsrd_pkg::FSM_DET_LEAD:
			begin
				if (st_reg.forceIdle && st_reg.idleCnt >= ppsrd_pkg::DET_LEAD_CYC)
				begin
					st_next.detRx = 1'b1;
					st_next.fsm = ppsrd_pkg::FSM_DET_WAIT;
				end
			end
			ppsrd_pkg::FSM_DET_WAIT:
			begin
				if (st_reg.doneS2)
				begin
					st_next.detRx = 1'b0;
					st_next.rawStat = st_reg.statS2;
					st_next.found = (st_reg.statS2 == ppsrd_pkg::STAT_RX_FOUND);
					st_next.detDone = 1'b1;
					st_next.fsm = ppsrd_pkg::FSM_IDLE;
				end
			end
		endcase
		// loopback only while settled in P0; the line is a don't-care in P0s and P2
		if (st_next.fsm == ppsrd_pkg::FSM_IDLE && st_next.pd == ppsrd_pkg::PS_P0)
			st_next.detRx = st_next.loopEn;
		else if (st_next.fsm != ppsrd_pkg::FSM_DET_WAIT)
			st_next.detRx = 1'b0;
		st_next.forceIdle = wantIdle(st_next.pd, st_next.beaconEn) || !holdOk;
		if (!st_next.forceIdle)
			st_next.idleCnt = 4'h0;
		else if (st_reg.forceIdle && st_reg.idleCnt != ppsrd_pkg::IDLE_CNT_MAX)
			st_next.idleCnt = st_reg.idleCnt + 4'h1;
		else if (!st_reg.forceIdle)
			st_next.idleCnt = 4'h0;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			st_reg <= '0;
			st_reg.pd <= ppsrd_pkg::RST_PS;
			st_reg.curPs <= ppsrd_pkg::RST_PS;
			st_reg.tgtPs <= ppsrd_pkg::RST_PS;
			st_reg.forceIdle <= 1'b1;
			st_reg.fsm <= ppsrd_pkg::FSM_IDLE;
		end
		else
			st_reg <= st_next;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign regs.rdata = (regs.addr == ppsrd_pkg::OFF_CTRL) ? {26'h0, st_reg.wide, st_reg.complEn,
		st_reg.beaconEn, st_reg.loopEn, st_reg.tgtPs}
		: (regs.addr == ppsrd_pkg::OFF_STATUS) ? {21'h0, st_reg.rawStat, 2'h0, st_reg.pwrDone,
		st_reg.found, st_reg.detDone, busy, st_reg.curPs} : 32'h00000000;
	// compliance only while settled in P0 with idle released
	assign tx.en = st_reg.complEn && st_reg.fsm == ppsrd_pkg::FSM_IDLE && st_reg.pd == ppsrd_pkg::PS_P0
		&& !st_reg.forceIdle;
	assign tx.wide = st_reg.wide;
	assign txPowerDown = st_reg.pd;
	assign txForceIdle = st_reg.forceIdle;
	assign txDetectRxLoop = st_reg.detRx;
	assign txData = tx.data;
	assign txCtrl = tx.ctrl;
	assign txForceDisp = tx.disp;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence detectLead;
		txForceIdle && $past(txForceIdle, 10) && $past(txForceIdle, 5);
	endsequence
	sequence detectEnd;
		st_reg.doneS2 ##1 !txDetectRxLoop && st_reg.detDone;
	endsequence

	p0_idle_low_a: assert property (@(posedge clock) disable iff (sys_rst)
		txPowerDown == ppsrd_pkg::PS_P0 |-> !txForceIdle)
		else $error("force-idle high in P0");
	low_idle_high_a: assert property (@(posedge clock) disable iff (sys_rst)
		txPowerDown == ppsrd_pkg::PS_P0S || txPowerDown == ppsrd_pkg::PS_P1 |-> txForceIdle)
		else $error("force-idle low in P0s or P1");
	p2_beacon_a: assert property (@(posedge clock) disable iff (sys_rst)
		txPowerDown == ppsrd_pkg::PS_P2 && !st_reg.beaconEn && $past(!st_reg.beaconEn) |-> txForceIdle)
		else $error("force-idle released in P2 without beacon");
	idle_min_a: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(txForceIdle) |-> txForceIdle[*4])
		else $error("electrical idle shorter than minimum");
	detect_lead_a: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(txDetectRxLoop) && txPowerDown == ppsrd_pkg::PS_P1 |-> detectLead)
		else $error("detect raised without force-idle lead");
	detect_both_a: assert property (@(posedge clock) disable iff (sys_rst)
		txDetectRxLoop && txPowerDown == ppsrd_pkg::PS_P1 |-> txForceIdle && st_reg.fsm == ppsrd_pkg::FSM_DET_WAIT)
		else $error("detect request without force-idle");
	detect_end_a: assert property (@(posedge clock) disable iff (sys_rst)
		st_reg.fsm == ppsrd_pkg::FSM_DET_WAIT && st_reg.doneS2 |-> detectEnd)
		else $error("detect not closed on completion");
	one_request_a: assert property (@(posedge clock) disable iff (sys_rst)
		st_reg.fsm == ppsrd_pkg::FSM_PWR_WAIT && !st_reg.doneS2 |=> $stable(txPowerDown))
		else $error("power request changed before completion");
	ps_change_a: assert property (@(posedge clock) disable iff (sys_rst)
		$changed(txPowerDown) |-> st_reg.fsm == ppsrd_pkg::FSM_PWR_WAIT && txPowerDown == st_reg.tgtPs)
		else $error("power code changed outside a request");
endmodule

// file: testbench/ppsrd_phy_model.sv
/*
 * Behavioural transceiver channel control: answers power and detect requests with a done pulse
 * and counts misuse of its control lines. Assumes the controller clock is the parallel clock.
 */
`timescale 1ns/1ps
module ppsrd_phy_model (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// controls
	input wire logic [1:0] txPowerDown,
	input wire logic txForceIdle,
	input wire logic txDetectRxLoop,
	// bench knobs
	input wire logic slow,
	input wire logic rxPresent,
	// answers
	output logic phyDoneStatus,
	output logic [2:0] phyStatus,
	output int violCount
);
	// ----
	// state
	// ----
	logic [1:0] psSeen;
	logic loopSeen;
	logic detPend;
	int waitCnt;
	int idleCnt;

	always @(posedge clock)
	begin
		phyDoneStatus <= 1'b0;
		// stale status keeps moving so a leftover value cannot pass
		phyStatus <= phyStatus + 3'h3;
		if (sys_rst)
		begin
			psSeen <= txPowerDown;
			loopSeen <= 1'b0;
			detPend <= 1'b0;
			waitCnt <= 0;
			idleCnt <= 0;
			violCount <= 0;
			phyStatus <= 3'h0;
		end
		else
		begin
			idleCnt <= txForceIdle ? idleCnt + 1 : 0;
			loopSeen <= txDetectRxLoop;
			if (waitCnt > 0)
				waitCnt <= waitCnt - 1;
			if (waitCnt == 1)
			begin
				phyDoneStatus <= 1'b1;
				phyStatus <= (detPend && rxPresent) ? 3'b011 : 3'b000;
				detPend <= 1'b0;
			end
			if (txPowerDown != psSeen)
			begin
				psSeen <= txPowerDown;
				waitCnt <= slow ? 9 : 2;
				if (waitCnt > 0)
					violCount <= violCount + 1;
			end
			if (txDetectRxLoop && !loopSeen && txPowerDown == 2'b10)
			begin
				detPend <= 1'b1;
				waitCnt <= slow ? 14 : 3;
				if (idleCnt < 10)
					violCount <= violCount + 1;
			end
			if (!txForceIdle && idleCnt > 0 && idleCnt < 4)
				violCount <= violCount + 1;
			if (txPowerDown == psSeen && txPowerDown != 2'b11 && txForceIdle != (txPowerDown != 2'b00))
				violCount <= violCount + 1;
		end
	end
endmodule

// file: testbench/tb_top.sv
/*
 * Self-checking bench of the power-state and receiver-detect controller.
 * Assumes the behavioural channel model and a zero-wait single AHB-Lite slave.
 */
`timescale 1ns/1ps
module tb_top;
	// ----
	// signals
	// ----
	localparam logic [31:0] aCtrl = 32'(ppsrd_pkg::OFF_CTRL);
	localparam logic [31:0] aCmd = 32'(ppsrd_pkg::OFF_CMD);
	localparam logic [31:0] aStat = 32'(ppsrd_pkg::OFF_STATUS);
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hready;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [1:0] txPowerDown;
	logic txForceIdle;
	logic txDetectRxLoop;
	logic [15:0] txData;
	logic [1:0] txCtrl;
	logic [1:0] txForceDisp;
	logic phyDoneStatus;
	logic [2:0] phyStatus;
	logic slow = 1'b0;
	logic rxPresent = 1'b0;
	int violCount;
	int bad_count = 0;
	int compares = 0;
	int cycles = 0;
	int seed = 32'hd8992f47;
	int expPs = 2;
	logic [31:0] rdat;
	logic [31:0] rnd;
	logic [1:0] ps;

	always #2.5 clock = ~clock;
	assign hready = hreadyout;

	ppsrd_ctrl i_dut (.clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .txPowerDown(txPowerDown), .txForceIdle(txForceIdle),
		.txDetectRxLoop(txDetectRxLoop), .txData(txData), .txCtrl(txCtrl), .txForceDisp(txForceDisp),
		.phyDoneStatus(phyDoneStatus), .phyStatus(phyStatus));
	ppsrd_phy_model i_phy (.clock(clock), .sys_rst(sys_rst), .txPowerDown(txPowerDown),
		.txForceIdle(txForceIdle), .txDetectRxLoop(txDetectRxLoop), .slow(slow), .rxPresent(rxPresent),
		.phyDoneStatus(phyDoneStatus), .phyStatus(phyStatus), .violCount(violCount));

	// ----
	// checks and bus cycles
	// ----
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			bad_count++;
			report_and_stop();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// entered just after a rising edge; waits on hready at each phase
	task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= addr;
		hwrite <= wr;
		hsize <= 3'h2;
		do @(posedge clock); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clock); while (hready !== 1'b1);
		rdat = hrdata;
		if (hresp !== 1'b0)
			chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
		xfer(1'b1, addr, wd);
	endtask

	task automatic rd(input logic [31:0] addr);
		xfer(1'b0, addr, 32'h0);
	endtask

	// ----
	// scenarios
	// ----
	task automatic goPs(input logic [1:0] nps, input logic beacon);
		logic idleExp;
		slow <= 1'($random(seed));
		wr(aCtrl, {28'h0, beacon, 1'b0, nps});
		wr(aCmd, 32'h1);
		rdat = 32'h0;
		while (rdat[ppsrd_pkg::ST_PWRDONE_BIT] !== 1'b1) rd(aStat);
		expPs = nps;
		idleExp = (nps == ppsrd_pkg::PS_P0) ? 1'b0 : (nps == ppsrd_pkg::PS_P2) ? !beacon : 1'b1;
		chk("status", {28'h0, 2'b10, nps}, {28'h0, rdat[5], rdat[2], rdat[1:0]});
		chk("power code", 32'(expPs), {30'h0, txPowerDown});
		chk("force idle", {31'h0, idleExp}, {31'h0, txForceIdle});
		wr(aStat, 32'h20);
		rd(aStat);
		chk("done cleared", 32'h0, {31'h0, rdat[5]});
	endtask

	task automatic detect(input logic present);
		rxPresent <= present;
		slow <= 1'($random(seed));
		wr(aCmd, 32'h2);
		rdat = 32'h0;
		while (rdat[ppsrd_pkg::ST_DETDONE_BIT] !== 1'b1) rd(aStat);
		chk("found", {31'h0, present}, {31'h0, rdat[4]});
		chk("raw status", present ? 32'h3 : 32'h0, {29'h0, rdat[10:8]});
		chk("detect line", 32'h0, {31'h0, txDetectRxLoop});
		chk("power code", 32'h2, {30'h0, txPowerDown});
		wr(aStat, 32'h8);
	endtask

	task automatic compl(input logic wide);
		logic [19:0] pat[4];
		int n;
		if (wide)
			pat = '{{ppsrd_pkg::SYM_D21_5, ppsrd_pkg::SYM_K28_5, 4'b0101},
				{ppsrd_pkg::SYM_D10_2, ppsrd_pkg::SYM_K28_5, 4'b0100},
				{ppsrd_pkg::SYM_D21_5, ppsrd_pkg::SYM_K28_5, 4'b0101},
				{ppsrd_pkg::SYM_D10_2, ppsrd_pkg::SYM_K28_5, 4'b0100}};
		else
			pat = '{{8'h00, ppsrd_pkg::SYM_K28_5, 4'b0101}, {8'h00, ppsrd_pkg::SYM_D21_5, 4'b0000},
				{8'h00, ppsrd_pkg::SYM_K28_5, 4'b0100}, {8'h00, ppsrd_pkg::SYM_D10_2, 4'b0000}};
		wr(aCtrl, {26'h0, wide, 5'h10});
		n = 0;
		do
		begin
			@(negedge clock);
			n++;
		end
		while (txForceDisp === 2'b00 && n < 40);
		for (int i = 0; i < 8; i++)
		begin
			chk("lane", {12'h0, pat[i % 4]}, {12'h0, txData, txCtrl, txForceDisp});
			@(negedge clock);
		end
		@(posedge clock);
		wr(aCtrl, 32'h0);
		$display("test compliance width %0d done", wide ? 16 : 8);
	endtask

	initial
	begin
		repeat (4) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		chk("reset code", 32'h2, {30'h0, txPowerDown});
		chk("reset idle", 32'h1, {31'h0, txForceIdle});
		rd(aCtrl);
		chk("ctrl reset", 32'h2, rdat);
		rd(aCmd);
		chk("cmd reads zero", 32'h0, rdat);
		wr(32'h0000000c, 32'hffffffff);
		rd(32'h0000000c);
		chk("unmapped", 32'h0, rdat);
		rnd = $random(seed) & 32'h3f;
		wr(aCtrl, rnd);
		rd(aCtrl);
		chk("ctrl rw", rnd, rdat);
		wr(aCtrl, 32'h2);
		$display("test registers done");
		repeat (12)
		begin
			ps = 2'($random(seed));
			if (ps == 2'(expPs))
				ps = ps + 2'h1;
			goPs(ps, 1'($random(seed)));
		end
		$display("test power walk done");
		if (expPs != 2)
			goPs(ppsrd_pkg::PS_P1, 1'b0);
		detect(1'b1);
		detect(1'b0);
		detect(1'($random(seed)));
		$display("test detect done");
		goPs(ppsrd_pkg::PS_P0, 1'b0);
		wr(aCmd, 32'h2);
		repeat (8) rd(aStat);
		chk("refused detect", 32'h0, {30'h0, rdat[3], txDetectRxLoop});
		wr(aCtrl, 32'h4);
		rd(aStat);
		rd(aStat);
		chk("loopback on", 32'h1, {31'h0, txDetectRxLoop});
		wr(aCtrl, 32'h0);
		rd(aStat);
		rd(aStat);
		chk("loopback off", 32'h0, {31'h0, txDetectRxLoop});
		$display("test loopback done");
		compl(1'b0);
		compl(1'b1);
		chk("pin misuse", 32'h0, violCount);
		report_and_stop();
	end
endmodule
